// File: timer2_regs.svh
// Purpose: Register offsets, field positions and reset values for the timer control block.
// Assumes: Wishbone byte addresses are four times the printed register index.
// Notes: Definitions only.
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH
`define IDX_TIMER_CONTROL 8'hc8
`define IDX_TIMER_MODE_CONTROL 8'hc9
`define IDX_CAPTURE_RELOAD_LOW 8'hca
`define IDX_CAPTURE_RELOAD_HIGH 8'hcb
`define IDX_COUNT_LOW 8'hcc
`define IDX_COUNT_HIGH 8'hcd
`define IDX_PORT_STATUS 8'hce
`define CTL_OVERFLOW_BIT 7
`define CTL_EXTERNAL_BIT 6
`define CTL_RX_CLOCK_BIT 5
`define CTL_TX_CLOCK_BIT 4
`define CTL_TRIGGER_EN_BIT 3
`define CTL_RUN_BIT 2
`define CTL_COUNTER_BIT 1
`define CTL_CAPTURE_BIT 0
`define MOD_PHASE_DIR_BIT 7
`define MOD_PHASE_MSB 6
`define MOD_PHASE_LSB 4
`define MOD_COUNT_MODE_MSB 3
`define MOD_COUNT_MODE_LSB 2
`define MOD_TOGGLE_BIT 1
`define MOD_UPDOWN_BIT 0
`define CONTROL_RESET 8'h00
`define MODE_RESET 8'h00
`define COUNT_RESET 16'h0000
`define RELOAD_RESET 16'h0000
`endif

// File: timer2_pkg.sv
// Purpose: Types shared by the timer control block.
// Assumes: Nothing beyond the register header.
// Notes: State of the block is held as one packed struct.
package timer2_pkg;
  // Operating mode chosen from the control and mode bits.
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_RELOAD = 3'b001,
    MODE_UPDOWN = 3'b010,
    MODE_CAPTURE = 3'b011,
    MODE_BAUD = 3'b100,
    MODE_FREQ = 3'b101
  } op_mode_type;

  // Whole register state of the block.
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic [1:0] count_sync;
    logic count_prev;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic ack;
    logic [7:0] rdata;
    logic overflow_pulse;
  } state_type;

  // Serial port clock sources handed out to the serial port.
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } baud_type;
endpackage

// File: timer2_ctrl.sv
// Purpose: Control, status and counting logic of a 16-bit timer behind a Wishbone slave.
// Assumes: Single 100 MHz clock, synchronous active-high reset, classic Wishbone master.
// Notes: Count and trigger pins are synchronised by two flip-flops before use.
// Behaviour
// - Overflow sets control bit 7; software clears.
// - No overflow flag while a serial clock selected.
// - Trigger falling edge event sets bit 6.
// - External flag requests interrupt when enabled.
// - No external interrupt in updown or dual-slope.
// - Bit 5 picks receive baud source.
// - Bit 4 picks transmit baud source.
// - Bit 3 enables trigger unless baud mode.
// - Bit 2 runs or holds the counter.
// - Bit 1 selects clock or external counting.
// - Capture copies count into reload pair.
// - Reload pair loads counter on overflow/trigger.
// - Serial clock select forces auto-reload.
// - Mode register field layout fixed.
// - Phase direction orders channel cycling.
// - Control and mode reset to zero.
// - Count bytes at 0CDH and 0CCH.
// - Reload bytes at 0CBH and 0CAH.
// - Mode selection follows fixed precedence.
// - External count after high-then-low samples.
`timescale 1ns/1ns
`default_nettype none
`include "timer2_regs.svh"

module timer2_ctrl
  import timer2_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic count_input_i,
  input wire logic trigger_input_i,
  input wire logic timer1_overflow_i,
  input wire logic timer_irq_enable_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic timer_irq_o,
  output logic overflow_pulse_o,
  output logic [2:0] phase_mode_o,
  output logic phase_direction_o,
  output logic [1:0] count_mode_o,
  output logic [2:0] op_mode_o
);

  // Current and next state.
  state_type state_q;
  state_type state_d;
  // Decoded mode, recomputed each cycle.
  op_mode_type op_mode;
  // Serial port clock routing.
  baud_type baud;
  // Bus strobes.
  logic bus_req;
  logic bus_wr;
  logic lane0;
  logic [7:0] reg_idx;
  logic [7:0] wbyte;
  // Named control bits for readability.
  logic rx_sel;
  logic tx_sel;
  logic baud_sel;
  logic run;
  logic trig_en;
  logic count_tick;
  logic trig_fall;
  logic ext_event;
  logic [16:0] count_inc;
  logic overflow;

  // A request is taken only while no ack is out, so a strobe held one cycle too long is answered once.
  assign bus_req = cyc_i && stb_i && !state_q.ack;
  assign bus_wr = bus_req && we_i;
  assign lane0 = sel_i[0];
  assign reg_idx = adr_i[9:2];
  assign wbyte = dat_i[7:0];
  // Control bits pulled out by name; the two flags are read in place where they are set.
  assign rx_sel = state_q.control[`CTL_RX_CLOCK_BIT];
  assign tx_sel = state_q.control[`CTL_TX_CLOCK_BIT];
  assign baud_sel = rx_sel || tx_sel;
  assign run = state_q.control[`CTL_RUN_BIT];
  // The trigger pin only counts when the timer is not clocking the serial port.
  assign trig_en = state_q.control[`CTL_TRIGGER_EN_BIT] && !baud_sel;
  // Falling edges seen on the synchronised pins; the first sync stage is never read here.
  assign trig_fall = state_q.trig_prev && !state_q.trig_sync[1];
  assign ext_event = trig_fall && trig_en && run;
  assign count_tick = state_q.control[`CTL_COUNTER_BIT] ?
                      (state_q.count_prev && !state_q.count_sync[1]) : 1'b1;
  // One bit wider than the count, so the carry out of the top bit marks the wrap.
  assign count_inc = {1'b0, state_q.count} + 17'h00001;
  // A stopped counter never wraps, which also keeps both flags quiet while it holds.
  assign overflow = run && count_tick && count_inc[16];

  // Mode precedence: baud, toggle, capture, updown, plain reload.
  always_comb begin
    if (!run) begin
      op_mode = MODE_OFF;
    end else if (baud_sel) begin
      op_mode = MODE_BAUD;
    end else if (state_q.mode[`MOD_TOGGLE_BIT]) begin
      op_mode = MODE_FREQ;
    end else if (state_q.control[`CTL_CAPTURE_BIT]) begin
      op_mode = MODE_CAPTURE;
    end else if (state_q.mode[`MOD_UPDOWN_BIT]) begin
      op_mode = MODE_UPDOWN;
    end else begin
      op_mode = MODE_RELOAD;
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    state_d = state_q;
    state_d.count_sync = {state_q.count_sync[0], count_input_i};
    state_d.count_prev = state_q.count_sync[1];
    state_d.trig_sync = {state_q.trig_sync[0], trigger_input_i};
    state_d.trig_prev = state_q.trig_sync[1];
    // Single-cycle ack; drops the cycle after it is given.
    state_d.ack = bus_req;
    state_d.overflow_pulse = overflow;
    // Software writes come first so hardware events below override them.
    if (bus_wr && lane0) begin
      case (reg_idx)
        `IDX_TIMER_CONTROL: state_d.control = wbyte;
        `IDX_TIMER_MODE_CONTROL: begin
          state_d.mode = wbyte;
          // Phase mode may only change while stopped.
          if (run) begin
            state_d.mode[`MOD_PHASE_MSB:`MOD_PHASE_LSB] = state_q.mode[`MOD_PHASE_MSB:`MOD_PHASE_LSB];
          end
        end
        `IDX_CAPTURE_RELOAD_LOW: state_d.reload[7:0] = wbyte;
        `IDX_CAPTURE_RELOAD_HIGH: state_d.reload[15:8] = wbyte;
        `IDX_COUNT_LOW: state_d.count[7:0] = wbyte;
        `IDX_COUNT_HIGH: state_d.count[15:8] = wbyte;
        default: begin
        end
      endcase
    end
    // Counting; a stopped counter holds its value.
    if (run && count_tick) begin
      if (overflow && (baud_sel || !state_q.control[`CTL_CAPTURE_BIT])) begin
        state_d.count = state_q.reload;
      end else begin
        state_d.count = count_inc[15:0];
      end
    end
    if (overflow && !baud_sel) begin
      state_d.control[`CTL_OVERFLOW_BIT] = 1'b1;
    end
    if (ext_event) begin
      if (state_q.control[`CTL_CAPTURE_BIT]) begin
        state_d.reload = state_q.count;
      end else begin
        state_d.count = state_q.reload;
      end
      state_d.control[`CTL_EXTERNAL_BIT] = 1'b1;
    end
    // Read data is registered alongside the ack.
    state_d.rdata = 8'h00;
    if (bus_req && !we_i) begin
      case (reg_idx)
        `IDX_TIMER_CONTROL: state_d.rdata = state_q.control;
        `IDX_TIMER_MODE_CONTROL: state_d.rdata = state_q.mode;
        `IDX_CAPTURE_RELOAD_LOW: state_d.rdata = state_q.reload[7:0];
        `IDX_CAPTURE_RELOAD_HIGH: state_d.rdata = state_q.reload[15:8];
        `IDX_COUNT_LOW: state_d.rdata = state_q.count[7:0];
        `IDX_COUNT_HIGH: state_d.rdata = state_q.count[15:8];
        `IDX_PORT_STATUS: state_d.rdata = {5'h00, op_mode};
        default: state_d.rdata = 8'h00;
      endcase
    end
  end

  // Register the state; reset clears control and mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.count_sync <= 2'h3;
      state_q.count_prev <= 1'b1;
      state_q.trig_sync <= 2'h3;
      state_q.trig_prev <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Serial port clock sources follow the select bits.
  assign baud.rx_tick = rx_sel ? state_q.overflow_pulse : timer1_overflow_i;
  assign baud.tx_tick = tx_sel ? state_q.overflow_pulse : timer1_overflow_i;
  assign rx_baud_tick_o = baud.rx_tick;
  assign tx_baud_tick_o = baud.tx_tick;
  // External flag is masked in updown and dual-slope modes.
  assign timer_irq_o = timer_irq_enable_i && (state_q.control[`CTL_OVERFLOW_BIT] ||
                       (state_q.control[`CTL_EXTERNAL_BIT] && !state_q.mode[`MOD_UPDOWN_BIT] &&
                        state_q.mode[`MOD_COUNT_MODE_MSB:`MOD_COUNT_MODE_LSB] == 2'h0));
  assign overflow_pulse_o = state_q.overflow_pulse;
  // Channel cycling order is applied by the compare array from this bit.
  assign phase_direction_o = state_q.mode[`MOD_PHASE_DIR_BIT];
  assign phase_mode_o = state_q.mode[`MOD_PHASE_MSB:`MOD_PHASE_LSB];
  assign count_mode_o = state_q.mode[`MOD_COUNT_MODE_MSB:`MOD_COUNT_MODE_LSB];
  assign op_mode_o = op_mode;
  assign ack_o = state_q.ack;
  assign dat_o = {24'h000000, state_q.rdata};

  // Every counted wrap outside baud mode raises the overflow flag.
  a_overflow_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !baud_sel |=> state_q.control[`CTL_OVERFLOW_BIT])
    else $error("overflow flag not set");

  // Hardware never clears the overflow flag; only a control write may.
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q.control[`CTL_OVERFLOW_BIT] && !(bus_wr && reg_idx == `IDX_TIMER_CONTROL)
      |=> state_q.control[`CTL_OVERFLOW_BIT])
    else $error("overflow flag cleared by hardware");

  // With a serial clock selected the overflow flag must not rise on its own.
  a_baud_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_sel && !state_q.control[`CTL_OVERFLOW_BIT] && !(bus_wr && reg_idx == `IDX_TIMER_CONTROL)
      |=> !state_q.control[`CTL_OVERFLOW_BIT])
    else $error("overflow flag set in baud mode");

  // A trigger event always leaves the external flag set.
  a_ext_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_event |=> state_q.control[`CTL_EXTERNAL_BIT])
    else $error("external flag not set");

  // Hardware never clears the external flag either.
  a_ext_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q.control[`CTL_EXTERNAL_BIT] && !(bus_wr && reg_idx == `IDX_TIMER_CONTROL)
      |=> state_q.control[`CTL_EXTERNAL_BIT])
    else $error("external flag cleared by hardware");

  // An enabled interrupt follows a set external flag in the standard count mode.
  a_irq_request: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_irq_enable_i && state_q.control[`CTL_EXTERNAL_BIT] && !state_q.mode[`MOD_UPDOWN_BIT] &&
      state_q.mode[`MOD_COUNT_MODE_MSB:`MOD_COUNT_MODE_LSB] == 2'h0 |-> timer_irq_o)
    else $error("external flag did not request irq");

  // Up/down counting keeps the external flag from the interrupt.
  a_irq_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q.mode[`MOD_UPDOWN_BIT] && !state_q.control[`CTL_OVERFLOW_BIT] |-> !timer_irq_o)
    else $error("irq in updown mode");

  // A dual-slope count mode also keeps the external flag from the interrupt.
  a_irq_slope: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q.mode[`MOD_COUNT_MODE_MSB:`MOD_COUNT_MODE_LSB] != 2'h0 && !state_q.control[`CTL_OVERFLOW_BIT]
      |-> !timer_irq_o)
    else $error("irq in dual-slope mode");

  // A wrap reaches the receive clock one cycle later when this timer is its source.
  a_rx_source: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_sel && overflow && !bus_wr |=> rx_baud_tick_o)
    else $error("receive clock missed an overflow");

  // The same holds for the transmit clock.
  a_tx_source: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_sel && overflow && !bus_wr |=> tx_baud_tick_o)
    else $error("transmit clock missed an overflow");

  // With the trigger disabled or the serial port clocked, the trigger pin changes nothing.
  a_trig_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    !trig_en && !state_q.control[`CTL_EXTERNAL_BIT] && !(bus_wr && reg_idx == `IDX_TIMER_CONTROL)
      |=> !state_q.control[`CTL_EXTERNAL_BIT])
    else $error("external flag set with trigger ignored");

  // A stopped counter holds its value unless software writes it.
  a_hold_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    !run && !bus_wr && !ext_event |=> state_q.count == $past(state_q.count))
    else $error("stopped count moved");

  // In timer function a running count steps by one on every clock.
  a_run_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    run && !state_q.control[`CTL_COUNTER_BIT] && !overflow && !ext_event && !bus_wr
      |=> state_q.count == $past(state_q.count) + 16'h0001)
    else $error("timer did not count a clock");

  // In counter function the count only moves on a seen high-then-low pair.
  a_count_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q.control[`CTL_COUNTER_BIT] && !ext_event && !bus_wr &&
      !(state_q.count_prev && !state_q.count_sync[1]) |=> state_q.count == $past(state_q.count))
    else $error("counter moved without a pin edge");

  // A capture event copies the live count into the reload pair.
  a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_event && state_q.control[`CTL_CAPTURE_BIT] |=> state_q.reload == $past(state_q.count))
    else $error("capture lost");

  // In reload mode a wrap loads the count from the reload pair.
  a_reload_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !state_q.control[`CTL_CAPTURE_BIT] && !ext_event && !bus_wr |=> state_q.count == $past(state_q.reload))
    else $error("reload missing");

  // In reload mode a trigger event loads the count as well.
  a_trig_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_event && !state_q.control[`CTL_CAPTURE_BIT] |=> state_q.count == $past(state_q.reload))
    else $error("trigger reload missing");

  // A serial clock select forces a reload on wrap whatever the capture bit says.
  a_baud_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && baud_sel && !bus_wr |=> state_q.count == $past(state_q.reload))
    else $error("baud mode did not reload");

  // The phase field may only change while stopped, so a running write leaves it alone.
  a_phase_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    run && bus_wr && reg_idx == `IDX_TIMER_MODE_CONTROL
      |=> phase_mode_o == $past(phase_mode_o))
    else $error("phase field changed while running");

  // Reset leaves control and mode at zero and the bus quiet.
  a_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> state_q.control == `CONTROL_RESET && state_q.mode == `MODE_RESET && !ack_o)
    else $error("reset left state behind");

  // Every taken request is answered on the next cycle.
  a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> ack_o)
    else $error("request not acknowledged");

  // The ack is a single-cycle pulse.
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

  // Read data is zero whenever no answer stands, so stale bytes never leak.
  a_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h00000000)
    else $error("read data without ack");

  // A cleared run bit always reports the off mode.
  a_op_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !run |-> op_mode_o == MODE_OFF)
    else $error("mode reported while stopped");

  // A serial clock select wins over every other mode bit.
  a_op_baud: assert property (@(posedge clk_i) disable iff (rst_i)
    run && baud_sel |-> op_mode_o == MODE_BAUD)
    else $error("baud mode not selected");

  // An event and a clearing write in one cycle leave the flag set.
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_event && bus_wr && reg_idx == `IDX_TIMER_CONTROL |=> state_q.control[`CTL_EXTERNAL_BIT])
    else $error("clear beat a trigger event");
endmodule
`default_nettype wire

// File: cpu_model.sv
// Purpose: Processor core model that issues classic Wishbone single cycles.
// Assumes: The slave answers each request with ack_i; every wait is bounded.
// Notes: Signals change by non-blocking assignment after a rising edge, apart from the idle values set at time zero.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // The bus idles from time zero, so no request can precede reset release.
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // One single cycle; the request is held until ack is sampled high or 50 edges pass.
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h000000, wd};
    n = 0;
    ok = 1'b0;
    rd = 8'h00;
    while (!ok && n < 50) begin
      @(posedge clk_i);
      n++;
      // Read data is taken at the very edge that sees ack.
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        rd = dat_i[7:0];
      end
    end
    // Release after the answer; the next call waits an edge, so cyc stays low a cycle.
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_timer2_control_status_regs.sv
// Purpose: Self-checking bench for the timer control and status registers.
// Assumes: Pins are synchronised inside, so edges are held three cycles.
// Notes: Reload and baud counts start near wrap so the run stays short.
`timescale 1ns/1ns
`default_nettype none
`include "timer2_regs.svh"
module tb_timer2_control_status_regs import timer2_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, rx, tx, irq, dir;
  logic cnt_pin = 1'b1;
  logic trig_pin = 1'b1;
  logic t1_ovf = 1'b0;
  logic irq_en = 1'b0;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [2:0] phase, opm;
  logic [1:0] cmode;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  // System clock at 100 MHz.
  always #5 clk_i = ~clk_i;
  timer2_ctrl u_timer2_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .count_input_i(cnt_pin), .trigger_input_i(trig_pin),
    .timer1_overflow_i(t1_ovf), .timer_irq_enable_i(irq_en), .rx_baud_tick_o(rx), .tx_baud_tick_o(tx),
    .timer_irq_o(irq), .overflow_pulse_o(), .phase_mode_o(phase), .phase_direction_o(dir),
    .count_mode_o(cmode), .op_mode_o(opm));
  cpu_model u_cpu_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // Compares with case equality, so an unknown never passes.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A missing ack is a hang, so it ends the run at once.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    logic ok;
    u_cpu_model.xfer(w, idx, d, q, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH ack expected 1 seen 0");
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(what, exp, q);
  endtask
  // One falling edge on a pin, each level held long enough to survive the synchroniser.
  task automatic fall(input logic trig);
    @(posedge clk_i);
    if (trig) trig_pin <= 1'b0;
    else cnt_pin <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (trig) trig_pin <= 1'b1;
    else cnt_pin <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    wr(`IDX_COUNT_LOW, c[7:0]);
    wr(`IDX_COUNT_HIGH, c[15:8]);
    wr(`IDX_CAPTURE_RELOAD_LOW, r[7:0]);
    wr(`IDX_CAPTURE_RELOAD_HIGH, r[15:8]);
  endtask
  task automatic t_reset();
    rc(`IDX_TIMER_CONTROL, 8'h00, "control");
    rc(`IDX_TIMER_MODE_CONTROL, 8'h00, "mode");
    rc(8'hcf, 8'h00, "unmapped");
    @(posedge clk_i);
    t1_ovf <= 1'b1;
    #1;
    chk("rx_tick", 8'h01, {7'h00, rx});
    chk("tx_tick", 8'h01, {7'h00, tx});
    @(posedge clk_i);
    t1_ovf <= 1'b0;
    $display("test reset done");
  endtask
  task automatic t_reload();
    logic [7:0] a, b;
    load(16'hfff0, 16'hff00);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    chk("op_mode", 8'h01, {5'h00, opm});
    repeat (40) @(posedge clk_i);
    rc(`IDX_TIMER_CONTROL, 8'h84, "control");
    rc(`IDX_COUNT_HIGH, 8'hff, "count_high");
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rc(`IDX_TIMER_CONTROL, 8'h00, "control");
    bus(1'b0, `IDX_COUNT_LOW, 8'h00, a);
    bus(1'b0, `IDX_COUNT_LOW, 8'h00, b);
    chk("held_count", a, b);
    $display("test reload done");
  endtask
  task automatic t_baud();
    load(16'hfff0, 16'hff00);
    wr(`IDX_TIMER_CONTROL, 8'h35);
    chk("op_mode", 8'h04, {5'h00, opm});
    n = 0;
    while (n < 300 && !(rx === 1'b1 && tx === 1'b1)) begin
      @(posedge clk_i);
      n++;
    end
    chk("baud_ticks", 8'h01, {7'h00, rx & tx});
    rc(`IDX_TIMER_CONTROL, 8'h35, "control");
    rc(`IDX_COUNT_HIGH, 8'hff, "count_high");
    wr(`IDX_TIMER_CONTROL, 8'h00);
    $display("test baud done");
  endtask
  task automatic t_capture();
    load(16'h0000, 16'hffff);
    wr(`IDX_TIMER_CONTROL, 8'h05);
    fall(1'b1);
    rc(`IDX_TIMER_CONTROL, 8'h05, "control");
    wr(`IDX_TIMER_CONTROL, 8'h0d);
    chk("op_mode", 8'h03, {5'h00, opm});
    fall(1'b1);
    rc(`IDX_TIMER_CONTROL, 8'h4d, "control");
    rc(`IDX_CAPTURE_RELOAD_HIGH, 8'h00, "reload_high");
    irq_en <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wr(`IDX_TIMER_MODE_CONTROL, 8'h01);
    chk("irq_updown", 8'h00, {7'h00, irq});
    wr(`IDX_TIMER_MODE_CONTROL, 8'h04);
    chk("irq_slope", 8'h00, {7'h00, irq});
    wr(`IDX_TIMER_MODE_CONTROL, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    irq_en <= 1'b0;
    load(16'h0000, 16'hab00);
    wr(`IDX_TIMER_CONTROL, 8'h0c);
    fall(1'b1);
    rc(`IDX_TIMER_CONTROL, 8'h4c, "control");
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rc(`IDX_COUNT_HIGH, 8'hab, "count_high");
    $display("test capture done");
  endtask
  task automatic t_counter();
    load(16'h0000, 16'h0000);
    wr(`IDX_TIMER_CONTROL, 8'h06);
    repeat (5) fall(1'b0);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rc(`IDX_COUNT_LOW, 8'h05, "count_low");
    rc(`IDX_COUNT_HIGH, 8'h00, "count_high");
    $display("test counter done");
  endtask
  task automatic t_mode();
    wr(`IDX_TIMER_MODE_CONTROL, 8'hff);
    rc(`IDX_TIMER_MODE_CONTROL, 8'hff, "mode");
    chk("phase_mode", 8'h07, {5'h00, phase});
    chk("phase_dir", 8'h01, {7'h00, dir});
    chk("count_mode", 8'h03, {6'h00, cmode});
    chk("op_mode", 8'h00, {5'h00, opm});
    wr(`IDX_TIMER_CONTROL, 8'h04);
    chk("op_mode", 8'h05, {5'h00, opm});
    wr(`IDX_TIMER_MODE_CONTROL, 8'h01);
    rc(`IDX_TIMER_MODE_CONTROL, 8'h71, "mode");
    chk("op_mode", 8'h02, {5'h00, opm});
    wr(`IDX_TIMER_CONTROL, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`IDX_TIMER_MODE_CONTROL, 8'h00, "mode");
    $display("test mode done");
  endtask
  // Reset for twelve cycles, then every scenario in turn.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_reload();
    t_baud();
    t_capture();
    t_counter();
    t_mode();
    end_sim();
  end
endmodule
`default_nettype wire
